// ---- common/ucr_core_if.sv ----
/*
 * Link between the channel control logic and its bit engine.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface ucr_core_if;
	logic [15:0] div;
	logic        pre4;
	logic        os8;
	logic        ir;
	logic        tx_valid;
	logic [7:0]  tx_data;
	logic        tx_take;
	logic        tx_busy;
	logic        tx_line;
	logic        rx_line;
	logic        rx_valid;
	logic [7:0]  rx_data;
	modport core (input div, pre4, os8, ir, tx_valid, tx_data, rx_line,
		output tx_take, tx_busy, tx_line, rx_valid, rx_data);
	modport ctl (output div, pre4, os8, ir, tx_valid, tx_data, rx_line,
		input tx_take, tx_busy, tx_line, rx_valid, rx_data);
endinterface

// ---- common/ucr_pkg.sv ----
/*
 * Constants for one serial channel: register indices, bit positions,
 * reset values and timing counts.
 * Assumes the register port carries 8-bit data and a 4-bit index.
 */
package ucr_pkg;
	localparam int        DATA_W       = 8;
	localparam int        ADDR_W       = 4;
	localparam int        DEF_FIFO     = 64;
	localparam int        DEF_DIV_W    = 16;
	// ----------------------------------------------------------------
	// Register indices
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_DATA    = 4'h0;
	localparam logic [3:0] REG_IER     = 4'h1;
	localparam logic [3:0] REG_MCR     = 4'h2;
	localparam logic [3:0] REG_FEATURE_CONTROL_REG    = 4'h3;
	localparam logic [3:0] REG_EFR     = 4'h4;
	localparam logic [3:0] REG_DIVL    = 4'h5;
	localparam logic [3:0] REG_DIVH    = 4'h6;
	localparam logic [3:0] REG_TRIG    = 4'h7;
	localparam logic [3:0] REG_HYST    = 4'h8;
	localparam logic [3:0] REG_XON     = 4'h9;
	localparam logic [3:0] REG_XOFF    = 4'ha;
	localparam logic [3:0] REG_TXLVL   = 4'hb;
	localparam logic [3:0] REG_RXLVL   = 4'hc;
	localparam logic [3:0] REG_MSR     = 4'hd;
	localparam logic [3:0] REG_LSR     = 4'he;
	// ----------------------------------------------------------------
	// Bit positions
	// ----------------------------------------------------------------
	localparam int MCR_DTR = 0, MCR_RTS = 1, MCR_OP2 = 3, MCR_IR = 6, MCR_PRE4 = 7;
	localparam int FEATURE_CONTROL_REG_RXINV = 2, FEATURE_CONTROL_REG_DIR = 3, FEATURE_CONTROL_REG_OS8 = 4;
	localparam int EFR_SWFC = 0, EFR_ARTS = 6, EFR_ACTS = 7;
	localparam int IER_RX = 0, IER_TX = 1, IER_CTS = 7;
	localparam int LSR_RXRDY = 0, LSR_OVR = 1, LSR_XOFF = 4, LSR_THRE = 5, LSR_TEMT = 6;
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  RST_TRIG   = 8'h20;
	localparam logic [7:0]  RST_HYST   = 8'h08;
	localparam logic [7:0]  RST_XON    = 8'h11;
	localparam logic [7:0]  RST_XOFF   = 8'h13;
	localparam logic [15:0] RST_DIV    = 16'h0001;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam logic [4:0] SAMP_16     = 5'h10;
	localparam logic [4:0] SAMP_8      = 5'h08;
	localparam logic [1:0] PRE4_LAST   = 2'h3;
	localparam logic [3:0] FRAME_BITS  = 4'ha;
	localparam int        CLK_PERIOD_NS = 50;
	localparam int        RST_MIN_NS    = 40;
	localparam int        RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic {UCR_IDLE, UCR_RUN} ucr_state_t;
endpackage

// ---- hdl/ucr_channel.sv ----
/*
 * One serial channel: registers, FIFOs, flow control, pins.
 * Assumes synchronous pins, one clock, and a host that issues one-cycle
 * strobes; instantiate twice for two channels.
 */
// The address-and-strobe port and the placing of the registers are this design's own decisions.
// Function
// - Software may invert the receive input ahead of the infrared decoder.
// - Auto RTS acts only with RTS asserted and auto RTS enabled.
// - CTS is a status input or gates transmit, with its own interrupt enable.
// - DSR, CD and RI are status only and steer nothing.
// - Control bit 3 set drives user output low and enables the interrupt driver.
// - Control bit 3 clear floats the interrupt output and drives user output high.
// - Reset longer than 40 ns returns every register and output to default.
// - During reset transmit stays high and receive is ignored.
// - Transmit idles high in standard mode and low in infrared mode.
// - The infrared path replaces the standard one only with control bit 6 set.
// - Two channels run independently, each with its own registers.
// - Each channel has 64-byte transmit and receive FIFOs with levels and trigger.
// - A prescaler divides the clock by 1 or 4 before the divisor.
// - Sampling is 16 or 8 baud ticks per bit, per channel.
// - Auto RTS has hysteresis; XON/XOFF characters pause and resume transmit.
// - In direction mode RTS is high for receive and low for transmit.
// - Direction returns to receive only after the last stop bit has left.
// - Direction goes to transmit as soon as a byte is loaded.
// - Direction control is off after reset, on when feature bit 3 is written 1.
`timescale 1ns/1ps
module ucr_channel
	import ucr_pkg::*;
#(
	parameter int FIFO_DEPTH = DEF_FIFO
) (
	input  wire logic                      i_clk_sys,
	input  wire logic                      i_rst,
	input  wire logic [ucr_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [ucr_pkg::DATA_W-1:0] i_wdata,
	input  wire logic                      i_wr,
	input  wire logic                      i_rd,
	output logic      [ucr_pkg::DATA_W-1:0] o_rdata,
	input  wire logic                      i_serial_rx_in,
	output logic                           o_serial_tx_out,
	output logic                           o_request_to_send_n,
	input  wire logic                      i_clear_to_send_n,
	output logic                           o_terminal_ready_n,
	input  wire logic                      i_data_set_ready_n,
	input  wire logic                      i_carrier_detect_n,
	input  wire logic                      i_ring_indicator_n,
	output logic                           o_user_output_two_n,
	output logic                           o_channel_irq,
	output logic                           o_channel_irq_oe
);
	import ucr_pkg::*;
	localparam int PW = $clog2(FIFO_DEPTH);
	localparam int CW = PW + 1;

	if (FIFO_DEPTH != 2 ** PW || FIFO_DEPTH < 2 || FIFO_DEPTH > 128) begin : g_chk
		$error("FIFO_DEPTH must be a power of two from 2 to 128");
	end

	// Each instance holds its own registers and FIFOs, so channels never share state.
	ucr_core_if cif ();

	ucr_core u_core (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.bus       (cif.core)
	);

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	logic [7:0]  ier_q, ier_d, mcr_q, mcr_d, feature_control_reg_q, feature_control_reg_d, efr_q, efr_d;
	logic [7:0]  trig_q, trig_d, hyst_q, hyst_d, xon_q, xon_d, xoff_q, xoff_d;
	logic [15:0] div_q, div_d;
	logic        wr_data, rd_data, rd_msr, rd_lsr;

	always_comb begin
		ier_d   = ier_q;
		mcr_d   = mcr_q;
		feature_control_reg_d  = feature_control_reg_q;
		efr_d   = efr_q;
		trig_d  = trig_q;
		hyst_d  = hyst_q;
		xon_d   = xon_q;
		xoff_d  = xoff_q;
		div_d   = div_q;
		wr_data = i_wr && i_addr == REG_DATA;
		rd_data = i_rd && i_addr == REG_DATA;
		rd_msr  = i_rd && i_addr == REG_MSR;
		rd_lsr  = i_rd && i_addr == REG_LSR;
		if (i_wr) begin
			case (i_addr)
				REG_IER:  ier_d = i_wdata;
				REG_MCR:  mcr_d = i_wdata;
				REG_FEATURE_CONTROL_REG: feature_control_reg_d = i_wdata;
				REG_EFR:  efr_d = i_wdata;
				REG_DIVL: div_d[7:0] = i_wdata;
				REG_DIVH: div_d[15:8] = i_wdata;
				REG_TRIG: trig_d = i_wdata;
				REG_HYST: hyst_d = i_wdata;
				REG_XON:  xon_d = i_wdata;
				REG_XOFF: xoff_d = i_wdata;
				default:  ier_d = ier_q;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			ier_q  <= 8'h00;
			mcr_q  <= 8'h00;
			feature_control_reg_q <= 8'h00;
			efr_q  <= 8'h00;
			trig_q <= RST_TRIG;
			hyst_q <= RST_HYST;
			xon_q  <= RST_XON;
			xoff_q <= RST_XOFF;
			div_q  <= RST_DIV;
		end else begin
			ier_q  <= ier_d;
			mcr_q  <= mcr_d;
			feature_control_reg_q <= feature_control_reg_d;
			efr_q  <= efr_d;
			trig_q <= trig_d;
			hyst_q <= hyst_d;
			xon_q  <= xon_d;
			xoff_q <= xoff_d;
			div_q  <= div_d;
		end
	end

	// ----------------------------------------------------------------
	// FIFOs and flow state
	// ----------------------------------------------------------------
	logic [7:0]    txm [FIFO_DEPTH];
	logic [7:0]    rxm [FIFO_DEPTH];
	logic [PW-1:0] twp_q, twp_d, trp_q, trp_d, rwp_q, rwp_d, rrp_q, rrp_d;
	logic [CW-1:0] tcnt_q, tcnt_d, rcnt_q, rcnt_d;
	logic          tpush, rpush, rpop, ctl_char;
	logic          ovr_q, ovr_d, paused_q, paused_d, rts_ok_q, rts_ok_d;
	logic          dir_q, dir_d, cts_prev_q, dcts_q, dcts_d, cts_ok;
	logic [8:0]    rlvl, rlow;

	always_comb begin
		tpush    = wr_data && tcnt_q != CW'(FIFO_DEPTH);
		ctl_char = efr_q[EFR_SWFC] && (cif.rx_data == xon_q || cif.rx_data == xoff_q);
		rpush    = cif.rx_valid && !ctl_char && rcnt_q != CW'(FIFO_DEPTH);
		rpop     = rd_data && rcnt_q != '0;
		twp_d    = tpush ? twp_q + PW'(1) : twp_q;
		trp_d    = cif.tx_take ? trp_q + PW'(1) : trp_q;
		rwp_d    = rpush ? rwp_q + PW'(1) : rwp_q;
		rrp_d    = rpop ? rrp_q + PW'(1) : rrp_q;
		tcnt_d   = tcnt_q + CW'(tpush) - CW'(cif.tx_take);
		rcnt_d   = rcnt_q + CW'(rpush) - CW'(rpop);
		// A character arriving to a full FIFO is lost; the flag records it.
		ovr_d    = (cif.rx_valid && !ctl_char && !rpush) || (ovr_q && !rd_lsr);
		paused_d = paused_q;
		if (!efr_q[EFR_SWFC]) begin
			paused_d = 1'b0;
		end else if (cif.rx_valid && cif.rx_data == xoff_q) begin
			paused_d = 1'b1;
		end else if (cif.rx_valid && cif.rx_data == xon_q) begin
			paused_d = 1'b0;
		end
		rlvl     = 9'(rcnt_q);
		rlow     = rlvl + {1'b0, hyst_q};
		rts_ok_d = rts_ok_q;
		if (rlvl >= {1'b0, trig_q}) begin
			rts_ok_d = 1'b0;
		end else if (rlow <= {1'b0, trig_q}) begin
			rts_ok_d = 1'b1;
		end
		dir_d = dir_q;
		if (tpush || cif.tx_take) begin
			dir_d = 1'b0;
		end else if (tcnt_q == '0 && !cif.tx_busy) begin
			dir_d = 1'b1;
		end
		dcts_d = (cts_prev_q != i_clear_to_send_n) || (dcts_q && !rd_msr);
		cts_ok = !efr_q[EFR_ACTS] || !i_clear_to_send_n;
		cif.tx_valid = tcnt_q != '0 && cts_ok && !paused_q;
		cif.tx_data  = txm[trp_q];
		cif.div      = div_q;
		cif.pre4     = mcr_q[MCR_PRE4];
		cif.os8      = feature_control_reg_q[FEATURE_CONTROL_REG_OS8];
		cif.ir       = mcr_q[MCR_IR];
	end

	always_ff @(posedge i_clk_sys) begin
		if (tpush) begin
			txm[twp_q] <= i_wdata;
		end
		if (rpush) begin
			rxm[rwp_q] <= cif.rx_data;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			twp_q      <= '0;
			trp_q      <= '0;
			rwp_q      <= '0;
			rrp_q      <= '0;
			tcnt_q     <= '0;
			rcnt_q     <= '0;
			ovr_q      <= 1'b0;
			paused_q   <= 1'b0;
			rts_ok_q   <= 1'b1;
			dir_q      <= 1'b1;
			cts_prev_q <= 1'b1;
			dcts_q     <= 1'b0;
		end else begin
			twp_q      <= twp_d;
			trp_q      <= trp_d;
			rwp_q      <= rwp_d;
			rrp_q      <= rrp_d;
			tcnt_q     <= tcnt_d;
			rcnt_q     <= rcnt_d;
			ovr_q      <= ovr_d;
			paused_q   <= paused_d;
			rts_ok_q   <= rts_ok_d;
			dir_q      <= dir_d;
			cts_prev_q <= i_clear_to_send_n;
			dcts_q     <= dcts_d;
		end
	end

	// ----------------------------------------------------------------
	// Read data and pins
	// ----------------------------------------------------------------
	logic [7:0] rdata_d, msr, lsr;
	logic       rxl_d, rxl_q, tx_d, rts_d, irq_d;

	always_comb begin
		// Modem inputs are reported here; CTS is also used elsewhere, to gate transmit and raise its interrupt.
		msr = {!i_carrier_detect_n, !i_ring_indicator_n, !i_data_set_ready_n,
			!i_clear_to_send_n, 3'h0, dcts_q};
		lsr = 8'h00;
		lsr[LSR_RXRDY] = rcnt_q != '0;
		lsr[LSR_OVR]   = ovr_q;
		lsr[LSR_XOFF]  = paused_q;
		lsr[LSR_THRE]  = tcnt_q == '0;
		lsr[LSR_TEMT]  = tcnt_q == '0 && !cif.tx_busy;
		rdata_d = 8'h00;
		if (i_rd) begin
			case (i_addr)
				REG_DATA:  rdata_d = rcnt_q != '0 ? rxm[rrp_q] : 8'h00;
				REG_IER:   rdata_d = ier_q;
				REG_MCR:   rdata_d = mcr_q;
				REG_FEATURE_CONTROL_REG:  rdata_d = feature_control_reg_q;
				REG_EFR:   rdata_d = efr_q;
				REG_DIVL:  rdata_d = div_q[7:0];
				REG_DIVH:  rdata_d = div_q[15:8];
				REG_TRIG:  rdata_d = trig_q;
				REG_HYST:  rdata_d = hyst_q;
				REG_XON:   rdata_d = xon_q;
				REG_XOFF:  rdata_d = xoff_q;
				REG_TXLVL: rdata_d = 8'(tcnt_q);
				REG_RXLVL: rdata_d = 8'(rcnt_q);
				REG_MSR:   rdata_d = msr;
				REG_LSR:   rdata_d = lsr;
				default:   rdata_d = 8'h00;
			endcase
		end
		// In infrared mode the pin idles low; the option flips it first.
		rxl_d = mcr_q[MCR_IR] ? !(i_serial_rx_in ^ feature_control_reg_q[FEATURE_CONTROL_REG_RXINV]) : i_serial_rx_in;
		cif.rx_line = rxl_q;
		tx_d = cif.tx_line;
		if (feature_control_reg_q[FEATURE_CONTROL_REG_DIR]) begin
			rts_d = dir_q;
		end else begin
			rts_d = !(mcr_q[MCR_RTS] && (!efr_q[EFR_ARTS] || rts_ok_q));
		end
		irq_d = (ier_q[IER_RX] && lsr[LSR_RXRDY]) || (ier_q[IER_TX] && lsr[LSR_TEMT])
			|| (ier_q[IER_CTS] && dcts_q);
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			o_rdata             <= 8'h00;
			rxl_q               <= 1'b1;
			o_serial_tx_out     <= 1'b1;
			o_request_to_send_n <= 1'b1;
			o_terminal_ready_n  <= 1'b1;
			o_user_output_two_n <= 1'b1;
			o_channel_irq       <= 1'b0;
			o_channel_irq_oe    <= 1'b0;
		end else begin
			o_rdata             <= rdata_d;
			rxl_q               <= rxl_d;
			o_serial_tx_out     <= tx_d;
			o_request_to_send_n <= rts_d;
			o_terminal_ready_n  <= !mcr_q[MCR_DTR];
			o_user_output_two_n <= !mcr_q[MCR_OP2];
			o_channel_irq       <= irq_d;
			o_channel_irq_oe    <= mcr_q[MCR_OP2];
		end
	end
endmodule

// ---- hdl/ucr_core.sv ----
/*
 * Bit engine: prescaler, divisor, transmit shifter and receive sampler.
 * Assumes rx_line is already registered and in idle-high polarity.
 */
`timescale 1ns/1ps
module ucr_core
	import ucr_pkg::*;
(
	input  wire logic  i_clk_sys,
	input  wire logic  i_rst,
	ucr_core_if.core   bus
);
	import ucr_pkg::*;
	// ----------------------------------------------------------------
	// Baud ticks
	// ----------------------------------------------------------------
	logic [1:0]  pre_q, pre_d;
	logic [15:0] dcnt_q, dcnt_d;
	logic        tick;
	logic        pre_en;
	logic [4:0]  nsb;
	ucr_state_t  txs_q, txs_d, rxs_q, rxs_d;
	logic [9:0]  tsh_q, tsh_d;
	logic [3:0]  tbit_q, tbit_d, rbit_q, rbit_d;
	logic [4:0]  tsmp_q, tsmp_d, rsmp_q, rsmp_d;
	logic [7:0]  rsh_q, rsh_d;
	logic        mid_q, mid_d, zero_q, zero_d, rv_q, rv_d;
	logic        bitv;

	always_comb begin
		nsb    = bus.os8 ? SAMP_8 : SAMP_16;
		pre_en = !bus.pre4 || pre_q == PRE4_LAST;
		pre_d  = bus.pre4 ? pre_q + 2'h1 : 2'h0;
		tick   = pre_en && (dcnt_q >= bus.div - 16'h0001);
		dcnt_d = !pre_en ? dcnt_q : (tick ? 16'h0000 : dcnt_q + 16'h0001);
	end

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	always_comb begin
		txs_d       = txs_q;
		tsh_d       = tsh_q;
		tbit_d      = tbit_q;
		tsmp_d      = tsmp_q;
		bus.tx_take = 1'b0;
		case (txs_q)
			UCR_IDLE: begin
				if (bus.tx_valid) begin
					bus.tx_take = 1'b1;
					tsh_d  = {1'b1, bus.tx_data, 1'b0};
					tbit_d = 4'h0;
					tsmp_d = 5'h00;
					txs_d  = UCR_RUN;
				end
			end
			UCR_RUN: begin
				if (tick) begin
					tsmp_d = tsmp_q + 5'h01;
					if (tsmp_q == nsb - 5'h01) begin
						tsmp_d = 5'h00;
						tsh_d  = {1'b1, tsh_q[9:1]};
						tbit_d = tbit_q + 4'h1;
						if (tbit_q == FRAME_BITS - 4'h1) begin
							txs_d = UCR_IDLE;
						end
					end
				end
			end
			default: txs_d = UCR_IDLE;
		endcase
		bus.tx_busy = txs_q == UCR_RUN;
		if (bus.ir) begin
			bus.tx_line = bus.tx_busy && !tsh_q[0] && tsmp_q[4:2] == 3'h0;
		end else begin
			bus.tx_line = !bus.tx_busy || tsh_q[0];
		end
	end

	// ----------------------------------------------------------------
	// Receiver
	// ----------------------------------------------------------------
	always_comb begin
		rxs_d  = rxs_q;
		rbit_d = rbit_q;
		rsmp_d = rsmp_q;
		rsh_d  = rsh_q;
		mid_d  = mid_q;
		zero_d = zero_q;
		rv_d   = 1'b0;
		bitv   = bus.ir ? !zero_q : mid_q;
		case (rxs_q)
			UCR_IDLE: begin
				if (tick && !bus.rx_line) begin
					rxs_d  = UCR_RUN;
					rbit_d = 4'h0;
					rsmp_d = 5'h01;
					zero_d = 1'b1;
					mid_d  = 1'b0;
				end
			end
			UCR_RUN: begin
				if (tick) begin
					rsmp_d = rsmp_q + 5'h01;
					zero_d = zero_q || !bus.rx_line;
					if (rsmp_q == {1'b0, nsb[4:1]}) begin
						mid_d = bus.rx_line;
					end
					if (rsmp_q == nsb - 5'h01) begin
						rsmp_d = 5'h00;
						zero_d = 1'b0;
						rbit_d = rbit_q + 4'h1;
						if (rbit_q == 4'h0 && bitv) begin
							rxs_d = UCR_IDLE;
						end else if (rbit_q == FRAME_BITS - 4'h1) begin
							rxs_d = UCR_IDLE;
							rv_d  = bitv;
						end else if (rbit_q != 4'h0) begin
							rsh_d = {bitv, rsh_q[7:1]};
						end
					end
				end
			end
			default: rxs_d = UCR_IDLE;
		endcase
		bus.rx_valid = rv_q;
		bus.rx_data  = rsh_q;
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			pre_q  <= 2'h0;
			dcnt_q <= 16'h0000;
			txs_q  <= UCR_IDLE;
			tsh_q  <= 10'h3ff;
			tbit_q <= 4'h0;
			tsmp_q <= 5'h00;
			rxs_q  <= UCR_IDLE;
			rbit_q <= 4'h0;
			rsmp_q <= 5'h00;
			rsh_q  <= 8'h00;
			mid_q  <= 1'b1;
			zero_q <= 1'b0;
			rv_q   <= 1'b0;
		end else begin
			pre_q  <= pre_d;
			dcnt_q <= dcnt_d;
			txs_q  <= txs_d;
			tsh_q  <= tsh_d;
			tbit_q <= tbit_d;
			tsmp_q <= tsmp_d;
			rxs_q  <= rxs_d;
			rbit_q <= rbit_d;
			rsmp_q <= rsmp_d;
			rsh_q  <= rsh_d;
			mid_q  <= mid_d;
			zero_q <= zero_d;
			rv_q   <= rv_d;
		end
	end
endmodule

// ---- sim/ucr_channel_props.sv ----
/*
 * Pin-level concurrent checks for one serial channel.
 * Assumes a bind to ucr_channel; only its ports are seen.
 */
`timescale 1ns/1ps
module ucr_channel_props
	import ucr_pkg::*;
(
	input wire logic                       i_clk_sys,
	input wire logic                       i_rst,
	input wire logic [ucr_pkg::ADDR_W-1:0] i_addr,
	input wire logic [ucr_pkg::DATA_W-1:0] i_wdata,
	input wire logic                       i_wr,
	input wire logic                       i_rd,
	input wire logic [ucr_pkg::DATA_W-1:0] o_rdata,
	input wire logic                       o_serial_tx_out,
	input wire logic                       o_request_to_send_n,
	input wire logic                       o_terminal_ready_n,
	input wire logic                       o_user_output_two_n,
	input wire logic                       o_channel_irq,
	input wire logic                       o_channel_irq_oe
);
	logic [7:0] mcr_q, mcr_d, feature_control_reg_q, feature_control_reg_d;
	logic [4:0] hi_q, hi_d;
	default clocking dc @(posedge i_clk_sys);
	endclocking
	// ----------------------------------------------------------------
	// Register shadows and idle-high run length
	// ----------------------------------------------------------------
	always_comb begin
		mcr_d = (i_wr && i_addr == REG_MCR) ? i_wdata : mcr_q;
		feature_control_reg_d = (i_wr && i_addr == REG_FEATURE_CONTROL_REG) ? i_wdata : feature_control_reg_q;
		hi_d = !o_serial_tx_out ? 5'h00 : ((hi_q == 5'h1f) ? hi_q : hi_q + 5'h01);
	end
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			mcr_q <= 8'h00;
			feature_control_reg_q <= 8'h00;
			hi_q <= 5'h00;
		end else begin
			mcr_q <= mcr_d;
			feature_control_reg_q <= feature_control_reg_d;
			hi_q <= hi_d;
		end
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_reset_tx_high: assert property (i_rst |=> o_serial_tx_out)
		else $error("transmit not high after reset");
	a_reset_outs_idle: assert property (i_rst |=> o_request_to_send_n && o_terminal_ready_n
		&& o_user_output_two_n && !o_channel_irq_oe && !o_channel_irq && o_rdata == 8'h00)
		else $error("outputs not at default after reset");
	a_op2_irq_pair: assert property (disable iff (i_rst)
		o_user_output_two_n != o_channel_irq_oe) else $error("user output and irq enable disagree");
	a_op2_write: assert property (disable iff (i_rst) (i_wr && i_addr == REG_MCR)
		|-> ##2 o_user_output_two_n == !$past(i_wdata[MCR_OP2], 2))
		else $error("user output does not follow control bit 3");
	a_rdata_one_cycle: assert property (disable iff (i_rst) !i_rd |=> o_rdata == 8'h00)
		else $error("read data present without a read");
	a_dir_tx_load: assert property (disable iff (i_rst)
		(feature_control_reg_q[FEATURE_CONTROL_REG_DIR] && i_wr && i_addr == REG_DATA) |-> ##2 !o_request_to_send_n)
		else $error("direction not set to transmit after load");
	a_dir_rx_late: assert property (disable iff (i_rst)
		($rose(o_request_to_send_n) && feature_control_reg_q[FEATURE_CONTROL_REG_DIR] && !mcr_q[MCR_IR]) |-> hi_q >= 5'h08)
		else $error("direction returned to receive before stop bit ended");
	a_rts_idle_high: assert property (disable iff (i_rst)
		(!feature_control_reg_q[FEATURE_CONTROL_REG_DIR] && !mcr_q[MCR_RTS]) |=> o_request_to_send_n)
		else $error("request pin asserted without enable");
endmodule
bind ucr_channel ucr_channel_props ucr_channel_props_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_serial_tx_out(o_serial_tx_out), .o_request_to_send_n(o_request_to_send_n),
	.o_terminal_ready_n(o_terminal_ready_n), .o_user_output_two_n(o_user_output_two_n),
	.o_channel_irq(o_channel_irq), .o_channel_irq_oe(o_channel_irq_oe));

// ---- sim/ucr_channel_tb.sv ----
/*
 * Self-checking bench for one serial channel.
 * Assumes the line model on the serial pins and a 20 MHz clock.
 */
`timescale 1ns/1ps
module ucr_channel_tb;
	import ucr_pkg::*;
	logic       i_clk_sys = 1'b0;
	logic       i_rst = 1'b1;
	logic [3:0] i_addr = 4'h0;
	logic [7:0] i_wdata = 8'h00;
	logic       i_wr = 1'b0;
	logic       i_rd = 1'b0;
	logic [7:0] o_rdata;
	logic       rx, tx, rts_n, dtr_n, op2_n, irq, irq_oe;
	logic       cts_n = 1'b0;
	logic [2:0] mdm_n = 3'h7;
	int         miscompares = 0;
	int         n_checks = 0;
	int         ntx = 0;
	logic [3:0] ra [8] = '{REG_TRIG, REG_HYST, REG_XON, REG_XOFF, REG_DIVL, REG_RXLVL, REG_MCR, 4'hf};
	logic [7:0] rv [8] = '{RST_TRIG, RST_HYST, RST_XON, RST_XOFF, RST_DIV[7:0], 8'h00, 8'h00, 8'h00};
	logic [7:0] cf [3] = '{8'h00, 8'h10, 8'h00};
	logic [7:0] cm [3] = '{8'h00, 8'h00, 8'h80};
	int         cc [3] = '{16, 8, 64};
	ucr_channel ucr_channel_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_serial_rx_in(rx),
		.o_serial_tx_out(tx), .o_request_to_send_n(rts_n), .i_clear_to_send_n(cts_n),
		.o_terminal_ready_n(dtr_n), .i_data_set_ready_n(mdm_n[0]),
		.i_carrier_detect_n(mdm_n[1]), .i_ring_indicator_n(mdm_n[2]),
		.o_user_output_two_n(op2_n), .o_channel_irq(irq), .o_channel_irq_oe(irq_oe));
	ucr_line_model ucr_line_model_i (.i_clk_sys(i_clk_sys), .i_tx(tx), .o_rx(rx));
	always #25 i_clk_sys = ~i_clk_sys;
	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge i_clk_sys);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask
	task automatic wait_got(input int n);
		for (int k = 0; k < 3000 && ucr_line_model_i.n_got < n; k++) @(posedge i_clk_sys);
		#1;
		chk(8'(ucr_line_model_i.n_got), 8'(n));
	endtask
	task automatic stop_test;
		$display("checks=%0d miscompares=%0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge i_clk_sys);
		ucr_line_model_i.idle();
		i_rst <= 1'b0;
		#1;
		chk({tx, rts_n, dtr_n, op2_n, irq_oe, irq, 2'b00}, 8'hf0);
		for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
		wr(REG_MCR, 8'h08);
		cyc(1);
		chk({6'h00, op2_n, irq_oe}, 8'h01);
		wr(REG_MCR, 8'h00);
		cyc(1);
		chk({6'h00, op2_n, irq_oe}, 8'h02);
		for (int i = 0; i < 3; i++) begin
			@(posedge i_clk_sys);
			mdm_n <= 3'(i);
			wr(REG_FEATURE_CONTROL_REG, cf[i]);
			wr(REG_MCR, cm[i]);
			ucr_line_model_i.bit_cyc = cc[i];
			ucr_line_model_i.send(8'h3c + 8'(i));
			cyc(4);
			rd(REG_RXLVL, 8'h01);
			rd(REG_DATA, 8'h3c + 8'(i));
			wr(REG_DATA, 8'hc0 + 8'(i));
			cyc(6);
			chk(8'(rts_n), 8'h01);
			ntx++;
			wait_got(ntx);
			chk(ucr_line_model_i.got, 8'hc0 + 8'(i));
			chk(8'(tx), 8'h01);
		end
		wr(REG_FEATURE_CONTROL_REG, 8'h00);
		wr(REG_MCR, 8'h00);
		ucr_line_model_i.bit_cyc = 16;
		wr(REG_EFR, 8'h80);
		@(posedge i_clk_sys);
		cts_n <= 1'b1;
		wr(REG_DATA, 8'h5a);
		cyc(24);
		chk(8'(tx), 8'h01);
		@(posedge i_clk_sys);
		cts_n <= 1'b0;
		ntx++;
		wait_got(ntx);
		chk(ucr_line_model_i.got, 8'h5a);
		wr(REG_IER, 8'h80);
		cyc(2);
		chk(8'(irq), 8'h01);
		rd(REG_MSR, 8'h71);
		cyc(2);
		chk(8'(irq), 8'h00);
		wr(REG_IER, 8'h00);
		wr(REG_EFR, 8'h00);
		wr(REG_FEATURE_CONTROL_REG, 8'h08);
		cyc(2);
		chk(8'(rts_n), 8'h01);
		wr(REG_DATA, 8'hc3);
		cyc(1);
		chk(8'(rts_n), 8'h00);
		wr(REG_DATA, 8'h96);
		ntx += 2;
		wait_got(ntx);
		chk(8'(rts_n), 8'h00);
		cyc(20);
		chk(8'(rts_n), 8'h01);
		chk(ucr_line_model_i.got, 8'h96);
		wr(REG_FEATURE_CONTROL_REG, 8'h00);
		wr(REG_HYST, 8'h00);
		wr(REG_TRIG, 8'h01);
		wr(REG_EFR, 8'h40);
		cyc(2);
		chk(8'(rts_n), 8'h01);
		wr(REG_MCR, 8'h02);
		cyc(2);
		chk(8'(rts_n), 8'h00);
		ucr_line_model_i.send(8'h77);
		cyc(4);
		chk(8'(rts_n), 8'h01);
		rd(REG_DATA, 8'h77);
		cyc(3);
		chk(8'(rts_n), 8'h00);
		wr(REG_MCR, 8'h00);
		wr(REG_EFR, 8'h01);
		ucr_line_model_i.send(RST_XOFF);
		cyc(4);
		wr(REG_DATA, 8'h69);
		cyc(40);
		chk(8'(tx), 8'h01);
		rd(REG_LSR, 8'h10);
		ucr_line_model_i.send(RST_XON);
		ntx++;
		wait_got(ntx);
		chk(ucr_line_model_i.got, 8'h69);
		rd(REG_RXLVL, 8'h00);
		wr(REG_EFR, 8'h00);
		wr(REG_FEATURE_CONTROL_REG, 8'h04);
		ucr_line_model_i.mode = 2'h2;
		wr(REG_MCR, 8'h40);
		cyc(2);
		chk(8'(tx), 8'h00);
		ucr_line_model_i.send(8'h3c);
		cyc(4);
		rd(REG_DATA, 8'h3c);
		wr(REG_MCR, 8'h00);
		ucr_line_model_i.mode = 2'h0;
		wr(REG_FEATURE_CONTROL_REG, 8'h00);
		wr(REG_MCR, 8'h0b);
		@(posedge i_clk_sys);
		i_rst <= 1'b1;
		@(posedge i_clk_sys);
		i_rst <= 1'b0;
		#1;
		chk({5'h00, rts_n, dtr_n, op2_n}, 8'h07);
		rd(REG_MCR, 8'h00);
		stop_test();
	end
	initial begin
		repeat (30000) @(posedge i_clk_sys);
		miscompares++;
		stop_test();
	end
endmodule

// ---- sim/ucr_line_model.sv ----
/*
 * Remote serial device: sends 8N1 frames, plain or infrared, and decodes transmit in plain mode only.
 * Assumes the bench sets bit_cyc and mode to match the channel setup.
 */
`timescale 1ns/1ps
module ucr_line_model (
	input  wire logic i_clk_sys,
	input  wire logic i_tx,
	output logic      o_rx
);
	int         bit_cyc = 16;
	logic [1:0] mode = 2'h0;
	logic [7:0] got;
	int         n_got = 0;
	// Line starts low so that receive blanking in reset is exercised.
	initial o_rx = 1'b0;
	function automatic logic lvl(input logic b, input int k);
		return (mode == 2'h0) ? b : ((!b && k < bit_cyc / 4) ^ mode[1]);
	endfunction
	task automatic idle;
		@(posedge i_clk_sys);
		o_rx <= lvl(1'b1, 0);
	endtask
	task automatic send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			for (int k = 0; k < bit_cyc; k++) begin
				@(posedge i_clk_sys);
				o_rx <= lvl(f[i], k);
			end
		end
		idle();
	endtask
	always begin
		@(negedge i_tx);
		if (mode == 2'h0) begin
			repeat (bit_cyc / 2) @(posedge i_clk_sys);
			for (int i = 0; i < 8; i++) begin
				repeat (bit_cyc) @(posedge i_clk_sys);
				got[i] = i_tx;
			end
			repeat (bit_cyc) @(posedge i_clk_sys);
			n_got++;
		end
	end
endmodule
